// ### rotate_pkg.sv
package rotate_pkg;
	localparam int DATA_W = 8;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam int OP_LATENCY = 1;

	typedef enum logic [2:0]
	{
		OP_LEFT_TO_WORK      = 3'h0,
		OP_LEFT_CARRY        = 3'h1,
		OP_LEFT_CARRY_WORK   = 3'h2,
		OP_RIGHT_IN_PLACE    = 3'h3,
		OP_RIGHT_TO_WORK     = 3'h4
	} rot_op_e;
endpackage

// ### rotate_if.sv
`timescale 1ns/1ps
interface rotate_if;
	logic [7:0] operand;
	logic       carryIn;
	logic [2:0] op;
	logic [7:0] result;
	logic       carryOut;
	logic       toWork;
	logic       carryUpdate;

	modport core
	(
		input  operand, carryIn, op,
		output result, carryOut, toWork, carryUpdate
	);
	modport ctrl
	(
		output operand, carryIn, op,
		input  result, carryOut, toWork, carryUpdate
	);
endinterface

// ### rotate_core.sv
`timescale 1ns/1ps
module rotate_core
(
	rotate_if.core rif
);
	always_comb
	begin
		rif.result = rif.operand;
		rif.carryOut = rif.carryIn;
		rif.toWork = 1'b0;
		rif.carryUpdate = 1'b0;
		case (rif.op)
			rotate_pkg::OP_LEFT_TO_WORK:
			begin
				rif.result = {rif.operand[6:0], rif.operand[7]};
				rif.toWork = 1'b1;
			end
			rotate_pkg::OP_LEFT_CARRY:
			begin
				rif.result = {rif.operand[6:0], rif.carryIn};
				rif.carryOut = rif.operand[7];
				rif.carryUpdate = 1'b1;
			end
			rotate_pkg::OP_LEFT_CARRY_WORK:
			begin
				rif.result = {rif.operand[6:0], rif.carryIn};
				rif.carryOut = rif.operand[7];
				rif.carryUpdate = 1'b1;
				rif.toWork = 1'b1;
			end
			rotate_pkg::OP_RIGHT_IN_PLACE:
				rif.result = {rif.operand[0], rif.operand[7:1]};
			rotate_pkg::OP_RIGHT_TO_WORK:
			begin
				rif.result = {rif.operand[0], rif.operand[7:1]};
				rif.toWork = 1'b1;
			end
			default:
				rif.result = rif.operand;
		endcase
	end
endmodule

// ### bit_rotate_unit.sv
`timescale 1ns/1ps
module bit_rotate_unit
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// decoder
	input  wire logic       opValid,
	input  wire logic [2:0] opCode,
	// data memory read
	input  wire logic [7:0] memReadData,
	// data memory write
	output logic            memWrite,
	output logic      [7:0] memWriteData,
	// architectural state
	output logic      [7:0] workReg,
	output logic            carryFlag,
	output logic            opDone
);
	rotate_if rif ();
	rotate_core u_core (.rif(rif));

	logic [7:0] work_reg;
	logic       carry_reg;
	logic       memWrite_reg;
	logic [7:0] memData_reg;
	logic       done_reg;
	logic       known;

	// codes 5 to 7 are ignored: no state may move
	function automatic logic known_op(input logic [2:0] code);
		known_op = code <= 3'h4;
	endfunction

	// codes whose result goes back to the memory byte
	function automatic logic is_mem_op(input logic [2:0] code);
		is_mem_op = code == rotate_pkg::OP_LEFT_CARRY
			|| code == rotate_pkg::OP_RIGHT_IN_PLACE;
	endfunction

	assign rif.operand = memReadData;
	assign rif.carryIn = carry_reg;
	assign rif.op = opCode;
	assign known = known_op(opCode);

	// destination write, one cycle per op
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			work_reg <= rotate_pkg::WORK_RESET;
		else if (opValid && known && rif.toWork)
			work_reg <= rif.result;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			carry_reg <= rotate_pkg::CARRY_RESET;
		else if (opValid && known && rif.carryUpdate)
			carry_reg <= rif.carryOut;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memWrite_reg <= 1'b0;
			memData_reg <= 8'h00;
			done_reg <= 1'b0;
		end
		else
		begin
			memWrite_reg <= opValid && known && !rif.toWork;
			if (opValid && known && !rif.toWork)
				memData_reg <= rif.result;
			done_reg <= opValid && known;
		end
	end

	assign workReg = work_reg;
	assign carryFlag = carry_reg;
	assign memWrite = memWrite_reg;
	assign memWriteData = memData_reg;
	assign opDone = done_reg;

	// rotate left forms
	a_left_work: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_TO_WORK
		|=> workReg == {$past(memReadData[6:0]), $past(memReadData[7])}
	)
		else $error("left to work wrong");

	a_left_quiet: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_TO_WORK
		|=> !memWrite && $stable(carryFlag)
	)
		else $error("left to work touched memory or carry");

	a_left_carry_mem: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY
		|=> memWrite
		&& memWriteData == {$past(memReadData[6:0]), $past(carryFlag)}
	)
		else $error("left via carry memory result wrong");

	a_left_carry_flag: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY
		|=> carryFlag == $past(memReadData[7])
		&& $stable(workReg)
	)
		else $error("left via carry flag wrong");

	a_lcw_result: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY_WORK
		|=> !memWrite
		&& workReg == {$past(memReadData[6:0]), $past(carryFlag)}
	)
		else $error("left via carry to work wrong");

	a_lcw_carry: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY_WORK
		|=> carryFlag == $past(memReadData[7])
	)
		else $error("carry not from bit 7");

	// rotate right forms
	a_right_mem: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_RIGHT_IN_PLACE
		|=> memWrite
		&& memWriteData == {$past(memReadData[0]), $past(memReadData[7:1])}
	)
		else $error("right in place wrong");

	a_right_quiet: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_RIGHT_IN_PLACE
		|=> $stable(carryFlag)
		&& $stable(workReg)
	)
		else $error("right in place touched carry or work");

	a_right_dest: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_RIGHT_TO_WORK
		|=> !memWrite && $stable(carryFlag)
	)
		else $error("right to work destination wrong");

	a_right_work: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_RIGHT_TO_WORK
		|=> workReg
		== {$past(memReadData[0]), $past(memReadData[7:1])}
	)
		else $error("right to work value wrong");

	// timing, idle cycles and ignored codes
	a_one_cycle: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && known_op(opCode)
		|=> opDone
		&& memWrite == is_mem_op($past(opCode))
	)
		else $error("op not done in one cycle");

	a_no_op_idle: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!opValid
		|=> !memWrite
		&& !opDone
		&& $stable(carryFlag)
		&& $stable(workReg)
	)
		else $error("state changed without op");

	a_refused_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && !known_op(opCode)
		|=> !memWrite
		&& !opDone
		&& $stable(carryFlag)
		&& $stable(workReg)
	)
		else $error("ignored code changed state");

	a_mem_data_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!(opValid && is_mem_op(opCode))
		|=> $stable(memWriteData)
	)
		else $error("memory data moved without memory op");

	// main scenarios
	c_left_carry: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY
		&& memReadData[7]);

	c_right_work: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid
		&& opCode == rotate_pkg::OP_RIGHT_TO_WORK);

	c_back_to_back: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid
		##1 opValid);

	c_refused: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid
		&& !known_op(opCode));

	c_carry_chain: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		opValid && opCode == rotate_pkg::OP_LEFT_CARRY
		##2 opValid && opCode == rotate_pkg::OP_LEFT_CARRY);
endmodule

// ### mem_model.sv
`timescale 1ns/1ps
module mem_model
(
	// clock
	input  wire logic       sys_clk,
	// write side
	input  wire logic       memWrite,
	input  wire logic [7:0] memWriteData,
	// read side
	output logic      [7:0] memReadData
);
	// one byte location; bench may preload it
	always @(posedge sys_clk)
		if (memWrite)
			memReadData <= memWriteData;
endmodule

// ### test_bit_rotate_unit.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module test_bit_rotate_unit;
	logic       sys_clk;
	logic       rst_n;
	logic       opValid;
	logic [2:0] opCode;
	logic [7:0] memReadData;
	logic       memWrite;
	logic [7:0] memWriteData;
	logic [7:0] workReg;
	logic       carryFlag;
	logic       opDone;
	logic [7:0] workExp;
	logic       carryExp;
	int         n_errors;
	int         checked;

	bit_rotate_unit dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.opValid(opValid), .opCode(opCode), .memReadData(memReadData),
		.memWrite(memWrite), .memWriteData(memWriteData),
		.workReg(workReg), .carryFlag(carryFlag), .opDone(opDone));
	mem_model mem (.sys_clk(sys_clk), .memWrite(memWrite),
		.memWriteData(memWriteData), .memReadData(memReadData));

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic step(input logic v, input logic [2:0] c);
		opValid = v;
		opCode = c;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic do_op(input logic [2:0] c, input bit ld, input logic [7:0] v);
		logic [7:0] r;
		if (ld)
			mem.memReadData = v;
		v = mem.memReadData;
		r = (c > 3'h2) ? {v[0], v[7:1]} : {v[6:0], c == 3'h0 ? v[7] : carryExp};
		if (c == 3'h1 || c == 3'h2)
			carryExp = v[7];
		if (c != 3'h1 && c != 3'h3)
			workExp = r;
		step(1'b1, c);
		`CHK("done", 1'b1, opDone)
		`CHK("wr", c == 3'h1 || c == 3'h3, memWrite)
		if (c == 3'h1 || c == 3'h3)
			`CHK("mem", r, memWriteData)
		`CHK("work", workExp, workReg)
		`CHK("carry", carryExp, carryFlag)
	endtask

	task automatic t_all;
		logic [7:0] pat [3];
		pat = '{8'h81, 8'h7e, 8'h01};
		for (int i = 0; i < 3; i++)
			for (int c = 0; c < 5; c++)
				do_op(c[2:0], 1'b1, pat[i]);
		step(1'b0, 3'h0);
	endtask

	// reset in mid-run, right after a memory op
	task automatic t_reset;
		do_op(3'h1, 1'b1, 8'h80);
		opValid = 1'b0;
		rst_n = 1'b0;
		#1;
		`CHK("rst2", 19'h00000, {workReg, carryFlag, opDone, memWrite, memWriteData})
		repeat (2) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		workExp = rotate_pkg::WORK_RESET;
		carryExp = rotate_pkg::CARRY_RESET;
		do_op(3'h2, 1'b1, 8'h01);
		step(1'b0, 3'h0);
	endtask

	// memory must settle between chained writes
	task automatic t_chain;
		do_op(3'h1, 1'b1, 8'h80);
		repeat (9)
		begin
			step(1'b0, 3'h0);
			`CHK("idle", 1'b0, opDone)
			do_op(3'h1, 1'b0, 8'h00);
		end
		step(1'b0, 3'h0);
	endtask

	task automatic t_refused;
		for (int c = 5; c < 8; c++)
		begin
			step(1'b1, c[2:0]);
			`CHK("ref", 2'b00, {opDone, memWrite})
			`CHK("refw", {workExp, carryExp}, {workReg, carryFlag})
		end
		step(1'b0, 3'h0);
	endtask

	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		n_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		opValid = 1'b0;
		opCode = 3'h0;
		mem.memReadData = 8'h00;
		workExp = rotate_pkg::WORK_RESET;
		carryExp = rotate_pkg::CARRY_RESET;
		repeat (3) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		`CHK("rst", {workExp, carryExp, 2'b00}, {workReg, carryFlag, opDone, memWrite})
		t_all();
		t_chain();
		t_refused();
		t_reset();
		finish_test();
	end
endmodule
